// ---- shared/mfc_pkg.sv ----
// Purpose: Constants and carrier types for the frame and FIFO threshold register slice.
// Assumes: Word-indexed register port, byte address equals four times the index.
// Notes:   Offsets are register indexes; the reduced variant fixes all seven fields, station words stay writable.
package mfc_pkg;

    localparam int unsigned      MFC_ADDR_W         = 10;
    localparam int unsigned      MFC_DATA_W         = 32;
    localparam int unsigned      MFC_FIELD_W        = 16;

    // Register indexes; the byte address is four times the index.
    localparam logic [7:0]       MFC_IDX_STA_LO     = 8'h03;
    localparam logic [7:0]       MFC_IDX_STA_HI     = 8'h04;
    localparam logic [7:0]       MFC_IDX_MAX_LEN    = 8'h05;
    localparam logic [7:0]       MFC_IDX_PAUSE      = 8'h06;
    localparam logic [7:0]       MFC_IDX_RX_DRAIN   = 8'h07;
    localparam logic [7:0]       MFC_IDX_RX_FWD     = 8'h08;
    localparam logic [7:0]       MFC_IDX_TX_DRAIN   = 8'h09;
    localparam logic [7:0]       MFC_IDX_TX_FWD     = 8'h0a;
    localparam logic [7:0]       MFC_IDX_RX_LOW     = 8'h0b;

    localparam logic [15:0]      MFC_MAX_LEN_RST    = 16'h05ee;
    localparam logic [15:0]      MFC_ZERO_RST       = 16'h0000;
    localparam logic [15:0]      MFC_FWD_FIXED      = 16'h0010;
    localparam logic [15:0]      MFC_DRAIN_MARGIN   = 16'h0010;
    localparam logic [15:0]      MFC_LOW_FIXED      = 16'h0008;
    localparam logic [31:0]      MFC_WORD_ZERO      = 32'h0000_0000;
    localparam logic [15:0]      MFC_HALF_ZERO      = 16'h0000;

    // Station address as stored: byte 0 in bits 7:0 of the low word.
    typedef struct packed {
        logic [15:0] hi;
        logic [31:0] lo;
    } mfc_station_t;

    // Thresholds and lengths handed to the MAC datapath.
    typedef struct packed {
        logic [15:0] max_len;
        logic [15:0] pause;
        logic [15:0] rx_drain;
        logic [15:0] rx_fwd;
        logic [15:0] tx_drain;
        logic [15:0] tx_fwd;
        logic [15:0] rx_low;
    } mfc_cfg_t;

    // Register port request from software.
    typedef struct packed {
        logic [9:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mfc_req_t;

endpackage

// ---- src/mfc_field_bank.sv ----
// Purpose: Small storage of sixteen-bit configuration fields with a registered read port.
// Assumes: One write and one read port on the same clock.
// Notes:   Read data appear one cycle after the read address.
`timescale 1ns/10ps
module mfc_field_bank
    import mfc_pkg::*;
#(
    parameter int unsigned DEPTH = 8                   // number of fields
) (
    input  wire logic                     clk_in,        // register clock
    input  wire logic                     rst_in,        // synchronous reset
    input  wire logic                     we_in,         // write enable
    input  wire logic [$clog2(DEPTH)-1:0] waddr_in,      // write index
    input  wire logic [15:0]              wdata_in,      // write data
    input  wire logic [$clog2(DEPTH)-1:0] raddr_in,      // read index
    input  wire logic [DEPTH*16-1:0]      init_in,       // reset image
    output logic      [15:0]              rdata_out,     // registered read data
    output logic      [DEPTH*16-1:0]      image_out      // whole contents
);

    if (DEPTH < 2) begin : g_depth_check
        $error("mfc_field_bank: DEPTH must be at least 2");
    end

    logic [DEPTH-1:0][15:0] mem_q;

    // Reset loads a constant image supplied by the parent as tied constants.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mem_q     <= init_in;
            rdata_out <= MFC_HALF_ZERO;
        end else begin
            if (we_in) begin
                mem_q[waddr_in] <= wdata_in;
            end
            rdata_out <= mem_q[raddr_in];
        end
    end

    assign image_out = mem_q;

endmodule

// ---- src/mfc_config_regs.sv ----
// Purpose: Frame length, pause quanta and FIFO threshold registers of a 10/100/1000 MAC.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes:   REDUCED selects the variant with fixed, read-only fields and no flow control; station words stay writable.
`timescale 1ns/10ps
module mfc_config_regs
    import mfc_pkg::*;
#(
    parameter bit          REDUCED    = 1'b0,          // fixed-field variant
    parameter int unsigned FIFO_DEPTH = 2048           // FIFO depth in words
) (
    input  wire logic              clk_in,             // register clock, 200 MHz
    input  wire logic              rst_in,             // synchronous reset
    input  wire logic [9:0]        addr_in,            // byte address
    input  wire logic [31:0]       wdata_in,           // write data
    input  wire logic              wr_in,              // write strobe
    input  wire logic              rd_in,              // read strobe
    input  wire logic              congested_in,       // local congestion request
    input  wire logic              rx_len_valid_in,    // receive frame length strobe
    input  wire logic [15:0]       rx_len_in,          // receive frame length
    output logic      [31:0]       rdata_out,          // read data
    output mfc_station_t           station_out,        // station address
    output mfc_cfg_t               cfg_out,            // thresholds and lengths
    output logic                   pause_send_out,     // pause frame request pulse
    output logic [15:0]            pause_quanta_out,   // quanta for pause frame
    output logic                   rx_too_long_out     // frame exceeded length pulse
);

    // The fixed drain level must stay positive and fit the sixteen-bit field.
    if (FIFO_DEPTH <= 16 || FIFO_DEPTH > 65535) begin : g_depth_check
        $error("mfc_config_regs: FIFO_DEPTH out of range");
    end

    // Fixed drain level of the reduced variant, depth less the margin.
    localparam logic [15:0] DRAIN_FIXED = 16'(FIFO_DEPTH) - MFC_DRAIN_MARGIN;

    // Field registers sit at consecutive indexes, so a slot is the offset from the first.
    function automatic logic [2:0] field_slot(input logic [7:0] idx);
        field_slot = 3'(idx - MFC_IDX_MAX_LEN);
    endfunction

    function automatic logic is_field(input logic [7:0] idx);
        is_field = (idx >= MFC_IDX_MAX_LEN) && (idx <= MFC_IDX_RX_LOW);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Everything the slice remembers outside the field bank, except the read index ridx_q, lives in this one record.
    typedef struct packed {
        mfc_station_t station;
        logic         rd_field;
        logic [31:0]  rdata;
        logic         pause_send;
        logic         congested;
        logic         too_long;
        mfc_cfg_t     cfg;
    } mfc_state_t;

    mfc_state_t s_q;
    mfc_state_t s_d;
    mfc_req_t   req;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic       fld_we;
    logic [15:0] fld_rdata;
    logic [127:0] fld_image;
    logic [127:0] fld_init;
    mfc_cfg_t   live;

    assign req  = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign widx = req.addr[9:2];
    assign ridx = req.addr[9:2];

    // Reduced variant rejects field writes; slot order follows the index order.
    assign fld_we   = req.wr && is_field(widx) && !REDUCED;
    assign fld_init = {MFC_HALF_ZERO, MFC_ZERO_RST, MFC_ZERO_RST, MFC_ZERO_RST,
                       MFC_ZERO_RST, MFC_ZERO_RST, MFC_ZERO_RST, MFC_MAX_LEN_RST};

    mfc_field_bank #(
        .DEPTH     (8)
    ) u_bank (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .we_in     (fld_we),
        .waddr_in  (field_slot(widx)),
        .wdata_in  (req.wdata[15:0]),
        .raddr_in  (field_slot(ridx)),
        .init_in   (fld_init),
        .rdata_out (fld_rdata),
        .image_out (fld_image)
    );

    // Live values: stored fields, or the fixed values in the reduced variant.
    // The reduced variant never looks at the bank, so its values cannot drift.
    always_comb begin
        if (REDUCED) begin
            live.max_len  = MFC_MAX_LEN_RST;
            live.pause    = MFC_ZERO_RST;
            live.rx_drain = DRAIN_FIXED;
            live.rx_fwd   = MFC_FWD_FIXED;
            live.tx_drain = DRAIN_FIXED;
            live.tx_fwd   = MFC_FWD_FIXED;
            live.rx_low   = MFC_LOW_FIXED;
        end else begin
            live.max_len  = fld_image[15:0];
            live.pause    = fld_image[31:16];
            live.rx_drain = fld_image[47:32];
            live.rx_fwd   = fld_image[63:48];
            live.tx_drain = fld_image[79:64];
            live.tx_fwd   = fld_image[95:80];
            live.rx_low   = fld_image[111:96];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d            = s_q;
        s_d.cfg        = live;
        s_d.rd_field   = req.rd && is_field(ridx);
        s_d.congested  = congested_in;
        // One pause request per rising edge of congestion; none when reduced.
        s_d.pause_send = congested_in && !s_q.congested && !REDUCED;
        // The limit is the registered copy shown on cfg_out, so the flag and the
        // published limit never disagree in the cycle after a length write.
        s_d.too_long   = rx_len_valid_in && (rx_len_in > s_q.cfg.max_len);
        // Station words are storage in both variants; the high word keeps its low half.
        if (req.wr && (widx == MFC_IDX_STA_LO)) begin
            s_d.station.lo = req.wdata;
        end
        if (req.wr && (widx == MFC_IDX_STA_HI)) begin
            s_d.station.hi = req.wdata[15:0];
        end
        // Read data stand only in the cycle after the strobe; unmapped reads give zero.
        s_d.rdata = MFC_WORD_ZERO;
        if (req.rd && (ridx == MFC_IDX_STA_LO)) begin
            s_d.rdata = s_d.station.lo;
        end
        if (req.rd && (ridx == MFC_IDX_STA_HI)) begin
            s_d.rdata = {MFC_HALF_ZERO, s_d.station.hi};
        end
    end

    // Reset restores the defaults; the reduced fixed values take over one edge later.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q     <= '0;
            s_q.cfg <= '{max_len: MFC_MAX_LEN_RST, default: MFC_ZERO_RST};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field reads come from the bank register; the reduced variant shows fixed values.
    function automatic logic [15:0] fixed_of(input logic [7:0] idx, input mfc_cfg_t c);
        case (idx)
            MFC_IDX_MAX_LEN:  fixed_of = c.max_len;
            MFC_IDX_PAUSE:    fixed_of = c.pause;
            MFC_IDX_RX_DRAIN: fixed_of = c.rx_drain;
            MFC_IDX_RX_FWD:   fixed_of = c.rx_fwd;
            MFC_IDX_TX_DRAIN: fixed_of = c.tx_drain;
            MFC_IDX_TX_FWD:   fixed_of = c.tx_fwd;
            MFC_IDX_RX_LOW:   fixed_of = c.rx_low;
            default:          fixed_of = MFC_HALF_ZERO;
        endcase
    endfunction

    // The read index is kept so the reduced variant can pick its fixed value a cycle later.
    logic [7:0] ridx_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ridx_q <= 8'h00;
        end else begin
            ridx_q <= ridx;
        end
    end

    // A registered flag picks the source, so the word never depends on the live address.
    // This last selection is not a flip-flop: the bank already spends the read cycle.
    always_comb begin
        if (s_q.rd_field) begin
            rdata_out = {MFC_HALF_ZERO,
                         REDUCED ? fixed_of(ridx_q, s_q.cfg) : fld_rdata};
        end else begin
            rdata_out = s_q.rdata;
        end
    end

    // All outputs but rdata_out are plain register copies; the quanta output feeds the pause builder.
    assign station_out      = s_q.station;
    assign cfg_out          = s_q.cfg;
    assign pause_send_out   = s_q.pause_send;
    assign pause_quanta_out = s_q.cfg.pause;
    assign rx_too_long_out  = s_q.too_long;

endmodule

// ---- tb/mfc_config_regs_asserts.sv ----
// Purpose: Port checks for the frame length, pause and threshold slice.
// Assumes: Bound to every instance; REDUCED and FIFO_DEPTH follow the target.
// Notes:   Reduced values are checked from the second edge after reset.
`timescale 1ns/10ps
module mfc_config_regs_asserts
    import mfc_pkg::*;
#(
    parameter bit          REDUCED    = 1'b0,     // fixed variant
    parameter int unsigned FIFO_DEPTH = 2048      // FIFO depth
) (
    input wire logic         clk_in,              // clock
    input wire logic         rst_in,              // reset
    input wire logic [9:0]   addr_in,             // address
    input wire logic [31:0]  wdata_in,            // write data
    input wire logic         wr_in,               // write strobe
    input wire logic         rd_in,               // read strobe
    input wire logic         congested_in,        // congestion
    input wire logic         rx_len_valid_in,     // length strobe
    input wire logic [15:0]  rx_len_in,           // length
    input wire logic [31:0]  rdata_out,           // read data
    input wire mfc_station_t station_out,         // station address
    input wire mfc_cfg_t     cfg_out,             // fields
    input wire logic         pause_send_out,      // pause pulse
    input wire logic [15:0]  pause_quanta_out,    // quanta
    input wire logic         rx_too_long_out      // too long pulse
);
    // Expected pause quanta: the last accepted write, delayed to match bank then state.
    logic [15:0] quanta_wr_q;
    logic [15:0] quanta_exp_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            quanta_wr_q  <= 16'h0000;
            quanta_exp_q <= 16'h0000;
        end else begin
            if (wr_in && addr_in[9:2] == 8'h06 && !REDUCED) begin
                quanta_wr_q <= wdata_in[15:0];
            end
            quanta_exp_q <= quanta_wr_q;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
        else $error("read data not zero outside a read");
    len_upper_a: assert property ($past(rd_in) && $past(addr_in[9:2]) == 8'h05
        |-> rdata_out[31:16] == 16'h0000) else $error("length upper half not zero");
    pause_upper_a: assert property ($past(rd_in) && $past(addr_in[9:2]) == 8'h06
        |-> rdata_out[31:16] == 16'h0000) else $error("pause upper half not zero");
    too_long_a: assert property (rx_len_valid_in && rx_len_in > cfg_out.max_len
        |=> rx_too_long_out) else $error("long frame not flagged");
    len_ok_a: assert property (!(rx_len_valid_in && rx_len_in > cfg_out.max_len)
        |=> !rx_too_long_out) else $error("frame flagged without cause");
    pause_req_a: assert property ($rose(congested_in) && !REDUCED |=> pause_send_out)
        else $error("no pause request on congestion");
    quanta_a: assert property (pause_quanta_out == quanta_exp_q
        && cfg_out.pause == quanta_exp_q) else $error("pause quanta differs from last write");
    no_pause_a: assert property (REDUCED |-> !pause_send_out)
        else $error("reduced variant sent pause");
    fixed_cfg_a: assert property (REDUCED && !$past(rst_in) |->
        cfg_out.max_len == 16'h05ee && cfg_out.rx_fwd == 16'h0010
        && cfg_out.tx_fwd == 16'h0010 && cfg_out.rx_low == 16'h0008
        && cfg_out.rx_drain == 16'(FIFO_DEPTH - 16) && cfg_out.tx_drain == 16'(FIFO_DEPTH - 16))
        else $error("reduced fields not fixed");
    long_c: cover property (rx_too_long_out);
    pause_c: cover property (pause_send_out);
    read_c: cover property (rd_in ##1 rdata_out != 32'h0000_0000);
endmodule
bind mfc_config_regs mfc_config_regs_asserts #(.REDUCED(REDUCED), .FIFO_DEPTH(FIFO_DEPTH))
    u_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .congested_in(congested_in),
        .rx_len_valid_in(rx_len_valid_in), .rx_len_in(rx_len_in), .rdata_out(rdata_out),
        .station_out(station_out), .cfg_out(cfg_out), .pause_send_out(pause_send_out),
        .pause_quanta_out(pause_quanta_out), .rx_too_long_out(rx_too_long_out));

// ---- tb/mfc_config_regs_tb.sv ----
// Purpose: Self-checking bench for the full and reduced register slice.
// Assumes: FIFO depth 64, so fixed drain levels are 48.
// Notes:   A word model per variant predicts every read and field.
`timescale 1ns/10ps
module mfc_config_regs_tb
    import mfc_pkg::*;
;
    logic         clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic         congested_in = 1'b0, rx_len_valid_in = 1'b0;
    logic [9:0]   addr_in = 10'h000;
    logic [31:0]  wdata_in = 32'h0000_0000;
    logic [15:0]  rx_len_in = 16'h0000, mx;
    logic [31:0]  rdo[2], m[2][16];
    mfc_station_t sto[2];
    mfc_cfg_t     cfo[2];
    logic         pso[2], tlo[2];
    logic [15:0]  pqo[2], lens[6];
    int           fails = 0, samples_checked = 0, cyc = 0;
    initial forever #2.5 clk_in = ~clk_in;
    for (genvar g = 0; g < 2; g++) begin : gi
        mfc_config_regs #(.REDUCED(g == 1), .FIFO_DEPTH(64)) dut (.clk_in, .rst_in, .addr_in,
            .wdata_in, .wr_in, .rd_in, .congested_in, .rx_len_valid_in, .rx_len_in,
            .rdata_out(rdo[g]), .station_out(sto[g]), .cfg_out(cfo[g]),
            .pause_send_out(pso[g]), .pause_quanta_out(pqo[g]), .rx_too_long_out(tlo[g]));
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Upper halves are dropped except at index 3; the reduced variant keeps only the station words.
    task automatic wr(input int i, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= 10'(i * 4);
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        m[0][i] = (i == 3) ? d : (i >= 4 && i <= 11) ? {16'h0000, d[15:0]} : m[0][i];
        if (i < 5) m[1][i] = m[0][i];
    endtask
    task automatic rd(input int i);
        @(posedge clk_in);
        addr_in <= 10'(i * 4);
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        for (int g = 0; g < 2; g++) chk(rdo[g], m[g][i]);
    endtask
    task automatic chk_cfg();
        repeat (2) @(posedge clk_in);
        #1;
        for (int g = 0; g < 2; g++) begin
            chk(cfo[g], {m[g][5][15:0], m[g][6][15:0], m[g][7][15:0], m[g][8][15:0],
                m[g][9][15:0], m[g][10][15:0], m[g][11][15:0]});
            chk(sto[g], {m[g][4][15:0], m[g][3]});
        end
    endtask
    task automatic ln(input logic [15:0] l);
        @(posedge clk_in);
        rx_len_valid_in <= 1'b1;
        rx_len_in <= l;
        @(posedge clk_in);
        rx_len_valid_in <= 1'b0;
        #1;
        for (int g = 0; g < 2; g++) chk(tlo[g], l > m[g][5][15:0]);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        m = '{default: '{default: 32'h0000_0000}};
        m[0][5] = 32'h0000_05ee;
        m[1] = '{5: 32'h0000_05ee, 7: 32'h0000_0030, 8: 32'h0000_0010, 9: 32'h0000_0030,
            10: 32'h0000_0010, 11: 32'h0000_0008, default: 32'h0000_0000};
        void'($urandom(45160));
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        for (int i = 0; i < 16; i++) rd(i);
        chk_cfg();
        for (int k = 0; k < 40; k++) wr(3 + $urandom_range(0, 9), $urandom());
        chk_cfg();
        for (int i = 0; i < 16; i++) rd(i);
        wr(3, 32'h1723_1c00);
        wr(4, 32'hffff_cb4a);
        chk_cfg();
        // Legal settings for depth 64: cut-through receive, store-and-forward transmit.
        wr(11, 32'h0000_0008);
        wr(8, 32'h0000_0010);
        wr(7, 32'h0000_0030);
        wr(10, 32'h0000_0000);
        wr(9, 32'h0000_0030);
        chk_cfg();
        for (int i = 7; i < 12; i++) rd(i);
        mx = 16'($urandom_range(16'h0100, 16'hfff0));
        wr(5, {16'hffff, mx});
        chk_cfg();
        lens = '{mx, mx + 16'h0001, mx - 16'h0001, 16'h05ee, 16'h05ef, 16'hffff};
        foreach (lens[j]) ln(lens[j]);
        wr(6, $urandom());
        chk_cfg();
        @(posedge clk_in);
        congested_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk({pso[0], pso[1], pqo[0], pqo[1]}, {2'b10, m[0][6][15:0], 16'h0000});
        @(posedge clk_in);
        congested_in <= 1'b0;
        #1;
        chk({pso[0], pso[1]}, 2'b00);
        // A second reset in mid-run must bring back the defaults in both variants.
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        m[0] = '{5: 32'h0000_05ee, default: 32'h0000_0000};
        m[1][3] = 32'h0000_0000;
        m[1][4] = 32'h0000_0000;
        chk_cfg();
        for (int i = 0; i < 16; i++) rd(i);
        test_done();
    end
endmodule
